// >>> verilog/ext_bus_pkg.sv
// Summary of operation
// - Mode 3 runs standard external bus cycles
// - Mode 0 always adds one wait state
// - Each wait lengthens strobe by two oscillator periods
// - Mode 0 cycle is two oscillator periods longer unless ready already adds a wait
// - Fail detector pulls reset low within 4-40 us
// - Detector enabled only by 0004H at 0778H
package ext_bus_pkg;

   // Core clock is the oscillator: one oscillator period per core_clk
   localparam int CLK_MHZ = 100;
   localparam int OSC_PER_WAIT = 2;
   localparam int STROBE_BASE = 2;
   localparam logic [1:0] STROBE_LAST = 2'h1;
   localparam logic [1:0] WAIT_LOAD = 2'(OSC_PER_WAIT);
   localparam logic [1:0] BASE_LOAD = 2'(STROBE_BASE);

   localparam logic [1:0] MODE_STANDARD = 2'h3;
   localparam logic [1:0] MODE_ONE_WAIT = 2'h0;

   localparam int FAIL_MIN_US = 4;
   localparam int FAIL_MAX_US = 40;
   localparam int FAIL_MIN_CYC = FAIL_MIN_US * CLK_MHZ;
   localparam int FAIL_MAX_CYC = FAIL_MAX_US * CLK_MHZ;
   localparam int FAIL_CNT_W = 12;
   localparam logic [FAIL_CNT_W-1:0] FAIL_TIMEOUT = FAIL_CNT_W'(FAIL_MIN_CYC);

   localparam logic [15:0] CFG_DETECT_LOC = 16'h0778;
   localparam logic [15:0] CFG_DETECT_VALUE = 16'h0004;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_HOLD,
      ST_STROBE,
      ST_RECOVER
   } bus_state_e;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic address_valid_strobe;
      logic rd_n;
      logic wr_n;
      logic [15:0] ad_out;
      logic ad_oe;
   } bus_pins_s;

endpackage

// >>> verilog/osc_fail_detect.sv
`timescale 1ns/1ps
module osc_fail_detect
   import ext_bus_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Monitored oscillator pin
   input wire logic osc_in,
   // Configuration image loader
   input wire logic cfg_load,
   input wire logic [15:0] cfg_addr,
   input wire logic [15:0] cfg_data,
   // Reset pull, low when failure seen
   output logic reset_pull_n,
   output logic fail_enabled
);

   logic osc_meta;
   logic osc_sync;
   logic osc_prev;
   logic [FAIL_CNT_W-1:0] gap_cnt;

   wire osc_edge = osc_sync ^ osc_prev;
   wire cfg_hit = cfg_load && (cfg_addr == CFG_DETECT_LOC);
   wire timed_out = gap_cnt >= FAIL_TIMEOUT;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_meta <= osc_in;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   // Only the exact enable word arms the detector
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fail_enabled <= 1'b0;
      end else if (cfg_hit) begin
         fail_enabled <= (cfg_data == CFG_DETECT_VALUE);
      end
   end

   // Gap of 4 us without an edge; sync lag keeps it far below 40 us
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_cnt <= '0;
      end else if (osc_edge || !fail_enabled) begin
         gap_cnt <= '0;
      end else if (!timed_out) begin
         gap_cnt <= gap_cnt + 1'b1;
      end
   end

   // Sticky until the system reset that it causes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_pull_n <= 1'b1;
      end else if (fail_enabled && timed_out) begin
         reset_pull_n <= 1'b0;
      end
   end

endmodule

// >>> verilog/ext_bus_ctrl.sv
`timescale 1ns/1ps
module ext_bus_ctrl
   import ext_bus_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Core request side
   input wire logic req_valid,
   input wire bus_req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   // Timing mode select
   input wire logic [1:0] bus_mode,
   // External bus pins
   input wire logic ready_pin,
   input wire logic [15:0] ad_in,
   output bus_pins_s pins,
   output logic clock_output_pin,
   // Oscillator fail detection
   input wire logic osc_in,
   input wire logic cfg_load,
   input wire logic [15:0] cfg_addr,
   input wire logic [15:0] cfg_data,
   output logic reset_pull_n,
   output logic clock_detect_enable_bit
);

   bus_state_e state;
   bus_state_e next_state;
   bus_req_s cur;
   logic cur_one_wait;
   logic wait_done;
   logic [1:0] phase_cnt;
   logic [1:0] next_cnt;
   logic ready_meta;
   logic ready_sync;
   logic [15:0] ad_meta;
   logic [15:0] ad_sync;

   // Active-low strobe, low only for the matching direction
   function automatic logic strobe_n(logic active, logic is_write, logic want_write);
      return !(active && (is_write == want_write));
   endfunction

   // Taken only while ready is shown, so no request slips in during reset
   wire take = (state == ST_IDLE) && req_valid && req_ready;
   wire strobe_end = (state == ST_STROBE) && (phase_cnt == STROBE_LAST);
   // Mode 0 forces the first wait regardless of ready
   wire forced_wait = cur_one_wait && !wait_done;
   wire need_wait = forced_wait || !ready_sync;
   wire add_wait = strobe_end && need_wait;
   wire finish = strobe_end && !need_wait;
   wire next_addr = (next_state == ST_ADDR);
   wire next_strobe = (next_state == ST_STROBE);
   wire next_data_oe = cur.write && ((next_state == ST_HOLD) || next_strobe);
   wire one_wait_sel = (bus_mode == MODE_ONE_WAIT);

   // Address comes from the request itself: cur only holds it after the take edge
   wire next_rd_n = strobe_n(next_strobe, cur.write, 1'b0);
   wire next_wr_n = strobe_n(next_strobe, cur.write, 1'b1);
   wire [15:0] next_ad_out = next_addr ? req.addr : cur.wdata;
   wire next_ad_oe = next_addr || next_data_oe;
   wire read_done = finish && !cur.write;
   wire next_rsp_valid = (state == ST_RECOVER);
   wire next_req_ready = (next_state == ST_IDLE);

   always_comb begin
      next_state = state;
      next_cnt = phase_cnt;
      unique case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_ADDR;
            end
         end
         ST_ADDR: begin
            next_state = ST_HOLD;
         end
         ST_HOLD: begin
            next_state = ST_STROBE;
            next_cnt = BASE_LOAD;
         end
         ST_STROBE: begin
            if (add_wait) begin
               next_cnt = WAIT_LOAD;
            end else if (finish) begin
               next_state = ST_RECOVER;
            end else begin
               next_cnt = phase_cnt - 1'b1;
            end
         end
         ST_RECOVER: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Pin inputs pass two flops before use
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_meta <= 1'b0;
         ready_sync <= 1'b0;
      end else begin
         ready_meta <= ready_pin;
         ready_sync <= ready_meta;
      end
   end

   // Data settles before the strobe ends, so the word cannot tear here
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ad_meta <= '0;
         ad_sync <= '0;
      end else begin
         ad_meta <= ad_in;
         ad_sync <= ad_meta;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Oscillator periods left in the current strobe phase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_cnt <= '0;
      end else begin
         phase_cnt <= next_cnt;
      end
   end

   // Mode is fixed for the whole cycle once the request is taken
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
         cur_one_wait <= 1'b0;
      end else if (take) begin
         cur <= req;
         cur_one_wait <= one_wait_sel;
      end
   end

   // Mode 0 spends its forced wait once per cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_done <= 1'b0;
      end else if (take) begin
         wait_done <= 1'b0;
      end else if (add_wait) begin
         wait_done <= 1'b1;
      end
   end

   // Read data stays until the next read ends
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_rdata <= '0;
      end else if (read_done) begin
         rsp_rdata <= ad_sync;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= next_rsp_valid;
      end
   end

   // Low in reset so no request is taken before the state is known
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= next_req_ready;
      end
   end

   // Pins registered from the next state so they line up with it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins.address_valid_strobe <= 1'b0;
         pins.rd_n <= 1'b1;
         pins.wr_n <= 1'b1;
         pins.ad_out <= '0;
         pins.ad_oe <= 1'b0;
      end else begin
         pins.address_valid_strobe <= next_addr;
         pins.rd_n <= next_rd_n;
         pins.wr_n <= next_wr_n;
         pins.ad_out <= next_ad_out;
         pins.ad_oe <= next_ad_oe;
      end
   end

   // Clock output runs at half the oscillator rate
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_output_pin <= 1'b0;
      end else begin
         clock_output_pin <= !clock_output_pin;
      end
   end

   osc_fail_detect oscillator_fail_detector (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .osc_in(osc_in),
      .cfg_load(cfg_load),
      .cfg_addr(cfg_addr),
      .cfg_data(cfg_data),
      .reset_pull_n(reset_pull_n),
      .fail_enabled(clock_detect_enable_bit)
   );

endmodule

// >>> verification/ext_bus_ctrl_properties.sv
`timescale 1ns/1ps
module ext_bus_ctrl_properties
   import ext_bus_pkg::*;
(
   // Clock, reset, core side
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic [1:0] bus_mode,
   // Bus and detector
   input wire logic ready_pin,
   input wire bus_pins_s pins,
   input wire logic osc_in,
   input wire logic reset_pull_n,
   input wire logic clock_detect_enable_bit,
   input wire logic clock_output_pin
);
   logic [11:0] idle;
   logic [3:0] low;
   logic osc_q;
   wire strobe = !pins.rd_n || !pins.wr_n;
   wire take = req_valid && req_ready;
   // Raw pin idle time, so the sync lag only adds margin
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle <= 12'h000;
         low <= 4'h0;
         osc_q <= 1'b0;
      end else begin
         osc_q <= osc_in;
         idle <= (osc_in != osc_q) ? 12'h000 : idle + {11'h000, idle != 12'hfff};
         low <= strobe ? low + 4'h1 : 4'h0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence std_take;
      take && bus_mode == MODE_STANDARD ##0 ready_pin [*5];
   endsequence
   sequence stalled;
      take ##2 !ready_pin [*3];
   endsequence
   ale_single_a: assert property (pins.address_valid_strobe |=> !pins.address_valid_strobe)
      else $error("address strobe wider than one cycle");
   std_done_a: assert property (std_take |-> ##2 rsp_valid)
      else $error("standard cycle not done in six cycles");
   forced_wait_a: assert property (take && bus_mode == MODE_ONE_WAIT |-> ##3 strobe [*4])
      else $error("mode zero strobe shorter than four cycles");
   wait_even_a: assert property ($fell(strobe) |-> low >= 4'h2 && !low[0])
      else $error("strobe not two plus two per wait");
   stall_ext_a: assert property (stalled |-> ##2 !rsp_valid)
      else $error("cycle ended while ready low");
   busy_take_a: assert property (take |=> !req_ready [*5])
      else $error("ready for request during cycle");
   pull_early_a: assert property ($fell(reset_pull_n) |-> idle >= FAIL_MIN_CYC)
      else $error("reset pulled before four us");
   pull_late_a: assert property (clock_detect_enable_bit && idle >= FAIL_MAX_CYC |-> !reset_pull_n)
      else $error("reset not pulled by forty us");
   clk_toggle_a: assert property ($past(rst_n) |-> clock_output_pin != $past(clock_output_pin))
      else $error("clock output not at half the oscillator rate");
   addr_drive_a: assert property (pins.address_valid_strobe |-> pins.ad_oe)
      else $error("address not driven during address strobe");
   read_float_a: assert property (!pins.rd_n |-> !pins.ad_oe)
      else $error("bus driven during read strobe");
endmodule

bind ext_bus_ctrl ext_bus_ctrl_properties ext_bus_ctrl_properties_i (.*);

// >>> verification/bus_mem_model.sv
`timescale 1ns/1ps
module bus_mem_model
   import ext_bus_pkg::*;
(
   // Clock and bench control
   input wire logic core_clk,
   input wire logic [3:0] stall,
   // Bus
   input wire bus_pins_s pins,
   output logic ready_pin,
   output logic [15:0] ad_in
);
   logic [15:0] mem [0:255];
   logic [7:0] a = 8'h00;
   logic [3:0] cnt = 4'h0;
   logic act = 1'b0;
   logic strb_q = 1'b0;
   logic [15:0] last = 16'h0000;
   assign ready_pin = cnt == 4'h0;
   // Released bus shows a changing value, never a stale word
   assign ad_in = act ? mem[a] : ~last;
   always @(posedge core_clk) begin
      strb_q <= !pins.rd_n || !pins.wr_n;
      last <= ad_in;
      if (pins.address_valid_strobe) begin
         a <= pins.ad_out[7:0];
         cnt <= stall;
         act <= 1'b1;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
      if (!pins.wr_n) begin
         mem[a] <= pins.ad_out;
      end
      if (strb_q && pins.rd_n && pins.wr_n) begin
         act <= 1'b0;
      end
   end
endmodule

// >>> verification/ext_bus_ctrl_tb.sv
`timescale 1ns/1ps
module ext_bus_ctrl_tb
   import ext_bus_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   bus_req_s req = '0;
   logic [1:0] bus_mode = 2'h3;
   logic osc_in = 1'b0;
   logic osc_run = 1'b1;
   logic cfg_load = 1'b0;
   logic [15:0] cfg_addr = 16'h0000;
   logic [15:0] cfg_data = 16'h0000;
   logic [3:0] stall = 4'h0;
   logic req_ready, rsp_valid, ready_pin, reset_pull_n, clock_detect_enable_bit;
   logic [15:0] rsp_rdata, ad_in;
   bus_pins_s pins;
   int bad_count = 0;
   int n_checks = 0;
   int seed = 32'h9f4d;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) osc_in <= osc_run ? ~osc_in : osc_in;
   ext_bus_ctrl ext_bus_ctrl_i (.*, .clock_output_pin());
   bus_mem_model bus_mem_model_i (.*);
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Stalls only bound the length: the sync lag makes the exact count fuzzy
   function automatic logic [15:0] lat_ok(int n, logic [1:0] m, logic [3:0] s);
      int base;
      // Take to response: address, hold, strobe, recover
      base = 3 + STROBE_BASE + ((m == MODE_ONE_WAIT) ? OSC_PER_WAIT : 0);
      return 16'(n >= base && (n - base) % 2 == 0 && n <= base + (s != 0 ? s + 4 : 0));
   endfunction
   task automatic xfer(logic w, logic [15:0] a, logic [15:0] d, logic [1:0] m, logic [3:0] s);
      int n;
      n = 0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req <= '{w, a, d};
      bus_mode <= m;
      stall <= s;
      @(posedge core_clk);
      req_valid <= 1'b0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 60);
      chk(lat_ok(n, m, s), 16'h0001);
      if (!w) chk(rsp_rdata, d);
   endtask
   task automatic cfg(logic [15:0] a, logic [15:0] d, logic exp);
      @(posedge core_clk);
      cfg_load <= 1'b1;
      cfg_addr <= a;
      cfg_data <= d;
      @(posedge core_clk);
      cfg_load <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(16'(clock_detect_enable_bit), 16'(exp));
   endtask
   initial begin
      int n;
      logic [15:0] a, d;
      logic [1:0] m;
      logic [3:0] s;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         a = 16'($random(seed));
         d = 16'($random(seed));
         m = (i < 4) ? 2'(i) : 2'($random(seed));
         s = (i % 3 == 2) ? 4'($random(seed) & 7) : 4'h0;
         xfer(1'b1, a, d, m, s);
         xfer(1'b0, a, d, m, s);
      end
      $display("test bus_cycles done");
      cfg(CFG_DETECT_LOC, 16'h0005, 1'b0);
      cfg(16'h0770, CFG_DETECT_VALUE, 1'b0);
      osc_run <= 1'b0;
      repeat (4200) @(posedge core_clk);
      chk(16'(reset_pull_n), 16'h0001);
      osc_run <= 1'b1;
      cfg(CFG_DETECT_LOC, CFG_DETECT_VALUE, 1'b1);
      @(posedge core_clk);
      osc_run <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (reset_pull_n !== 1'b0 && n < 5000);
      chk(16'(n >= FAIL_MIN_CYC && n <= FAIL_MAX_CYC), 16'h0001);
      // Run past the late bound so its check sees a long dead clock
      repeat (3700) @(posedge core_clk);
      #1;
      chk(16'(reset_pull_n), 16'h0000);
      $display("test osc_fail done");
      stop_test();
   end
   initial begin
      #300000;
      bad_count++;
      $display("watchdog expired");
      stop_test();
   end
endmodule
